// File: verilog/pmdc_defs.vh
// Register offsets, field positions, reset values and timing counts of the mode-control block.
`ifndef PMDC_DEFS_VH
`define PMDC_DEFS_VH
`define PMDC_ADDR_CTRL    8'h00
`define PMDC_ADDR_ABIL    8'h04
`define PMDC_ADDR_CTRL2   8'h08
`define PMDC_ADDR_STAT    8'h0C
`define PMDC_CTRL_FDX     8
`define PMDC_CTRL_AN_EN   12
`define PMDC_CTRL_SPD100  13
`define PMDC_CTRL2_GATE100 0
`define PMDC_CTRL2_GATE10  1
`define PMDC_CTRL_RST     3'h3
`define PMDC_ABIL_RST     4'hF
`define PMDC_CTRL2_RST    2'h0
`define PMDC_CLK_MHZ      125
`define PMDC_SQE_NS       1000
`define PMDC_SQE_CYC      ((`PMDC_SQE_NS * `PMDC_CLK_MHZ) / 1000)
`define PMDC_SCR_SEED     11'h7FF
`endif

// File: verilog/pmdc_top.v
// Mode, power-gating and duplex control of a 10/100 line interface with its coding paths and register slave.
//
// Operation
// - With the 100 Mbit/s gate bit set, the 100 Mbit/s modules are disabled while running at 10 Mbit/s.
// - With the 10 Mbit/s gate bit set, the 10 Mbit/s modules are disabled while running at 100 Mbit/s.
// - Control bit 12 enables auto-negotiation when set and disables it when cleared.
// - With auto-negotiation on, the highest mode common to both abilities is chosen.
// - At 100 Mbit/s nibbles are 4B/5B coded, scrambled and sent NRZI/MLT-3, and received in reverse.
// - Both speeds serialise transmit nibbles and rebuild receive nibbles, using Manchester at 10 Mbit/s.
// - In 10 Mbit/s full duplex there is no transmit loopback and no SQE test pulse.
// - In full duplex carrier sense follows receive only and collision stays low.
// - In half duplex carrier sense follows transmit or receive and collision marks receive during transmit.
//
// Design decisions made here: the APB slave port and the register offsets.
`timescale 1ns/100ps
`include "pmdc_defs.vh"

module pmdc_fifo #(
  parameter WIDTH = 4,
  parameter DEPTH = 4,
  parameter AW    = 2
) (
  input  wire             core_clk,
  input  wire             nrst,
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);
  localparam [AW:0] FULL = DEPTH;
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wptr_r;
  reg [AW-1:0]    rptr_r;
  reg [AW:0]      cnt_r;
  reg [AW:0]      cnt_nxt;
  reg             rdy_r;
  wire            push;
  wire            pop;

  // Handshakes on both sides; ready is a stored flag so it never races the writer.
  assign push      = in_valid & rdy_r;
  assign pop       = out_valid & out_ready;
  assign in_ready  = rdy_r;
  assign out_valid = (cnt_r != {(AW+1){1'b0}});
  assign out_data  = mem[rptr_r];

  // Occupancy after this cycle's push and pop.
  always @* begin
    cnt_nxt = cnt_r;
    if (push & ~pop) begin
      cnt_nxt = cnt_r + 1'b1;
    end else if (pop & ~push) begin
      cnt_nxt = cnt_r - 1'b1;
    end
  end

  // Pointers, count and the full flag.
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      wptr_r <= {AW{1'b0}};
      rptr_r <= {AW{1'b0}};
      cnt_r  <= {(AW+1){1'b0}};
      rdy_r  <= 1'b1;
    end else begin
      if (push) begin
        wptr_r <= wptr_r + 1'b1;
      end
      if (pop) begin
        rptr_r <= rptr_r + 1'b1;
      end
      cnt_r <= cnt_nxt;
      rdy_r <= (cnt_nxt != FULL);
    end
  end
  // Storage needs no reset; a word is only read after it was written.
  always @(posedge core_clk) begin
    if (push) begin
      mem[wptr_r] <= in_data;
    end
  end
endmodule

module pmdc_top (
  input  wire        core_clk,
  input  wire        nrst,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        tx_valid,
  output wire        tx_ready,
  input  wire [3:0]  txd,
  output reg  [3:0]  rxd_r,
  output reg         rx_dv_r,
  output reg         crs_r,
  output reg         col_r,
  output reg         tp_pos_r,
  output reg         tp_neg_r,
  output reg         tp_oe_r,
  input  wire        line_rx_pos,
  input  wire        line_rx_neg,
  input  wire        line_rx_act,
  input  wire [3:0]  lp_abil,
  input  wire        lp_abil_valid,
  output reg         en_100_r,
  output reg         en_10_r
);
  localparam [1:0]  ST_IDLE = 2'h0;
  localparam [1:0]  ST_SEND = 2'h1;
  localparam [11:0] SQE_CYC = `PMDC_SQE_CYC;
  // 4B/5B code groups of the sixteen data nibbles, nibble 0 in the low five bits.
  localparam [79:0] ENC_TAB = {5'h1D, 5'h1C, 5'h1B, 5'h1A, 5'h17, 5'h16, 5'h13, 5'h12,
                               5'h0F, 5'h0E, 5'h0B, 5'h0A, 5'h15, 5'h14, 5'h09, 5'h1E};

  reg  [31:0] rd_mux;
  reg  [11:0] sqe_r;
  reg  [10:0] tscr_r, rscr_r;
  reg  [7:0]  sync1_r, sync2_r;
  reg  [4:0]  tsh_r, rsh_r, tsh_nxt;
  reg  [3:0]  abil_r, tcnt_r, rcnt_r, tcnt_nxt;
  reg  [2:0]  ctrl_r;
  reg  [1:0]  ctrl2_r, st_r, mlt_r, lvl_r, st_nxt;
  reg         spd100_r, fdx_r, an_done_r, tmode_r, map_hit, load;
  wire [3:0]  lp_s, f_data, common;
  wire [1:0]  rlvl;
  wire        rxa, lp_v, f_valid, wr_en, tx_act, half10, tscr_bit, rbit, rdata;

  // Transmit nibbles from the MAC wait here; a full buffer holds the MAC off.
  pmdc_fifo #(.WIDTH(4), .DEPTH(4), .AW(2)) u_txq (
    .core_clk  (core_clk),
    .nrst      (nrst),
    .in_valid  (tx_valid),
    .in_ready  (tx_ready),
    .in_data   (txd),
    .out_valid (f_valid),
    .out_ready (load),
    .out_data  (f_data)
  );

  // Inverse of the 4B/5B code; unknown code groups decode to zero.
  function [3:0] dec4;
    input [4:0] c;
    integer     i;
    begin
      dec4 = 4'h0;
      for (i = 0; i < 16; i = i + 1) begin
        if (ENC_TAB[i*5 +: 5] == c) begin
          dec4 = i[3:0];
        end
      end
    end
  endfunction

  // Pins from the line and the partner pass two flip-flops before use.
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      sync1_r <= 8'h00;
      sync2_r <= 8'h00;
    end else begin
      sync1_r <= {lp_abil_valid, lp_abil, line_rx_act, line_rx_neg, line_rx_pos};
      sync2_r <= sync1_r;
    end
  end

  assign rlvl   = sync2_r[1:0];
  assign rxa    = sync2_r[2];
  assign lp_s   = sync2_r[6:3];
  assign lp_v   = sync2_r[7];
  assign common = abil_r & lp_s;
  assign tx_act = (st_r == ST_SEND);
  assign half10 = ~spd100_r & ~fdx_r;
  assign wr_en  = psel & penable & pready & pwrite;

  // Register read mux and address decode.
  always @* begin
    map_hit = 1'b1;
    rd_mux  = 32'h0000_0000;
    case (paddr)
      `PMDC_ADDR_CTRL: begin
        rd_mux[`PMDC_CTRL_FDX]    = ctrl_r[0];
        rd_mux[`PMDC_CTRL_AN_EN]  = ctrl_r[1];
        rd_mux[`PMDC_CTRL_SPD100] = ctrl_r[2];
      end
      `PMDC_ADDR_ABIL:  rd_mux[3:0] = abil_r;
      `PMDC_ADDR_CTRL2: rd_mux[1:0] = ctrl2_r;
      `PMDC_ADDR_STAT:  rd_mux[10:0] = {col_r, crs_r, lp_s, an_done_r, en_10_r, en_100_r, fdx_r, spd100_r};
      default: map_hit = 1'b0;
    endcase
  end

  // Zero-wait slave: the answer is prepared in setup and pready stands through the access cycle.
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
      ctrl_r  <= `PMDC_CTRL_RST;
      abil_r  <= `PMDC_ABIL_RST;
      ctrl2_r <= `PMDC_CTRL2_RST;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~map_hit;
      prdata  <= (psel & ~penable & ~pwrite) ? rd_mux : 32'h0000_0000;
      if (wr_en && paddr == `PMDC_ADDR_CTRL) begin
        ctrl_r <= {pwdata[`PMDC_CTRL_SPD100], pwdata[`PMDC_CTRL_AN_EN], pwdata[`PMDC_CTRL_FDX]};
      end
      if (wr_en && paddr == `PMDC_ADDR_ABIL) begin
        abil_r <= pwdata[3:0];
      end
      if (wr_en && paddr == `PMDC_ADDR_CTRL2) begin
        ctrl2_r <= pwdata[1:0];
      end
    end
  end

  // Operating mode: best common ability when negotiating, register bits otherwise.
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      spd100_r  <= 1'b0;
      fdx_r     <= 1'b0;
      an_done_r <= 1'b0;
      en_100_r  <= 1'b1;
      en_10_r   <= 1'b1;
    end else begin
      if (!ctrl_r[1]) begin
        spd100_r  <= ctrl_r[2];
        fdx_r     <= ctrl_r[0];
        an_done_r <= 1'b0;
      end else if (lp_v) begin
        spd100_r  <= common[3] | common[2];
        fdx_r     <= common[3] | (~common[2] & common[1]);
        an_done_r <= 1'b1;
      end else begin
        an_done_r <= 1'b0;
      end
      en_100_r <= ~(ctrl2_r[`PMDC_CTRL2_GATE100] & ~spd100_r);
      en_10_r  <= ~(ctrl2_r[`PMDC_CTRL2_GATE10] & spd100_r);
    end
  end

  // Transmit serialiser: a nibble is taken when the previous one has gone out.
  always @* begin
    load     = 1'b0;
    st_nxt   = st_r;
    tsh_nxt  = tsh_r;
    tcnt_nxt = tcnt_r;
    case (st_r)
      ST_IDLE, ST_SEND: begin
        if (st_r == ST_SEND && tcnt_r != 4'h1) begin
          tcnt_nxt = tcnt_r - 4'h1;
          if (!tmode_r || tcnt_r[0]) begin
            tsh_nxt = {1'b0, tsh_r[4:1]};
          end
        end else if (f_valid) begin
          load     = 1'b1;
          st_nxt   = ST_SEND;
          tsh_nxt  = spd100_r ? ENC_TAB[f_data*5 +: 5] : {1'b0, f_data};
          tcnt_nxt = spd100_r ? 4'h5 : 4'h8;
        end else begin
          st_nxt = ST_IDLE;
        end
      end
      default: st_nxt = ST_IDLE;
    endcase
  end
  assign tscr_bit = tsh_r[0] ^ tscr_r[10] ^ tscr_r[8];

  // Line driver: MLT-3 steps on every scrambled one, Manchester sends the inverse bit then the bit.
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      st_r     <= ST_IDLE;
      tsh_r    <= 5'h00;
      tcnt_r   <= 4'h0;
      tmode_r  <= 1'b0;
      tscr_r   <= `PMDC_SCR_SEED;
      mlt_r    <= 2'h0;
      tp_pos_r <= 1'b0;
      tp_neg_r <= 1'b0;
      tp_oe_r  <= 1'b0;
    end else begin
      st_r   <= st_nxt;
      tsh_r  <= tsh_nxt;
      tcnt_r <= tcnt_nxt;
      if (load) begin
        tmode_r <= ~spd100_r;
      end
      tp_oe_r <= tx_act;
      if (!tx_act) begin
        tscr_r   <= `PMDC_SCR_SEED;
        mlt_r    <= 2'h0;
        tp_pos_r <= 1'b0;
        tp_neg_r <= 1'b0;
      end else if (!tmode_r && en_100_r) begin
        tscr_r   <= {tscr_r[9:0], tscr_r[10] ^ tscr_r[8]};
        mlt_r    <= mlt_r + {1'b0, tscr_bit};
        tp_pos_r <= ((mlt_r + {1'b0, tscr_bit}) == 2'h1);
        tp_neg_r <= ((mlt_r + {1'b0, tscr_bit}) == 2'h3);
      end else if (tmode_r && en_10_r) begin
        tp_pos_r <= ~(tsh_r[0] ^ tcnt_r[0]);
        tp_neg_r <= tsh_r[0] ^ tcnt_r[0];
      end
    end
  end
  assign rbit  = (rlvl != lvl_r);
  assign rdata = rbit ^ rscr_r[10] ^ rscr_r[8];

  // Receive rebuild, loopback, carrier sense, collision and SQE test.
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rscr_r  <= `PMDC_SCR_SEED;
      lvl_r   <= 2'h0;
      rsh_r   <= 5'h00;
      rcnt_r  <= 4'h0;
      rxd_r   <= 4'h0;
      rx_dv_r <= 1'b0;
      crs_r   <= 1'b0;
      col_r   <= 1'b0;
      sqe_r   <= 12'h000;
    end else begin
      rx_dv_r <= 1'b0;
      if (!rxa) begin
        rscr_r <= `PMDC_SCR_SEED;
        lvl_r  <= 2'h0;
        rcnt_r <= 4'h0;
        if (load && half10) begin
          rxd_r   <= f_data;
          rx_dv_r <= 1'b1;
        end
      end else if (spd100_r && en_100_r) begin
        lvl_r  <= rlvl;
        rscr_r <= {rscr_r[9:0], rscr_r[10] ^ rscr_r[8]};
        rsh_r  <= {rdata, rsh_r[4:1]};
        rcnt_r <= (rcnt_r == 4'h4) ? 4'h0 : rcnt_r + 4'h1;
        if (rcnt_r == 4'h4) begin
          rxd_r   <= dec4({rdata, rsh_r[4:1]});
          rx_dv_r <= 1'b1;
        end
      end else if (!spd100_r && en_10_r) begin
        rcnt_r <= (rcnt_r == 4'h7) ? 4'h0 : rcnt_r + 4'h1;
        if (!rcnt_r[0]) begin
          rsh_r <= {~rlvl[0], rsh_r[4:1]};
        end
        if (rcnt_r == 4'h7) begin
          rxd_r   <= rsh_r[4:1];
          rx_dv_r <= 1'b1;
        end
      end
      if (tx_act && st_nxt == ST_IDLE && half10) begin
        sqe_r <= SQE_CYC;
      end else if (sqe_r != 12'h000) begin
        sqe_r <= sqe_r - 12'h001;
      end
      if (fdx_r) begin
        crs_r <= rxa;
        col_r <= 1'b0;
      end else begin
        crs_r <= rxa | tx_act;
        col_r <= (rxa & tx_act) | (sqe_r != 12'h000);
      end
    end
  end
endmodule

// File: dv/pmdc_sva.sv
// Port checker of the mode-control block.
`timescale 1ns/100ps
module pmdc_sva (
  input wire        core_clk,
  input wire        nrst,
  input wire        psel,
  input wire        penable,
  input wire [7:0]  paddr,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  input wire        tx_valid,
  input wire        tx_ready,
  input wire        rx_dv_r,
  input wire        tp_pos_r,
  input wire        tp_neg_r,
  input wire        en_100_r,
  input wire        en_10_r
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  // Setup cycle and unmapped address decode.
  wire setup = psel && !penable;
  wire bad   = paddr > 8'h0C || paddr[1:0] != 2'b00;
  a_apb_answer: assert property (setup |=> pready) else $error("no answer");
  a_ready_pulse: assert property (pready |=> !pready) else $error("long ready");
  a_err_unmapped: assert property (setup && bad |=> pslverr) else $error("no error");
  a_err_mapped: assert property (setup && !bad |=> !pslverr) else $error("false error");
  a_rdata_idle: assert property (!pready |-> prdata == 32'h0000_0000) else $error("rdata");
  a_one_speed_on: assert property (en_100_r || en_10_r) else $error("both off");
  a_line_excl: assert property (!(tp_pos_r && tp_neg_r)) else $error("line both");
  a_rxdv_gap: assert property (rx_dv_r |=> !rx_dv_r [*4]) else $error("dv gap");
  a_full_cause: assert property ($fell(tx_ready) |-> $past(tx_valid)) else $error("full");
  // Main scenarios reached.
  cover property (pready && pslverr);
  cover property (rx_dv_r);
  cover property (!en_10_r);
  cover property (!en_100_r);
endmodule

// File: dv/pmdc_lp_model.sv
// Link partner model: abilities and a 10 Mbit/s Manchester receive stream.
`timescale 1ns/100ps
module pmdc_lp_model (
  input  wire       core_clk,
  output reg        line_rx_pos,
  output reg        line_rx_neg,
  output reg        line_rx_act,
  output reg  [3:0] lp_abil,
  output reg        lp_abil_valid
);
  // Quiet line and no abilities at start.
  initial begin
    line_rx_pos = 1'b0;
    line_rx_neg = 1'b1;
    line_rx_act = 1'b0;
    lp_abil = 4'h0;
    lp_abil_valid = 1'b0;
  end
  // Offers the partner's abilities.
  task set_abil(input [3:0] a);
    begin
      lp_abil <= a;
      lp_abil_valid <= 1'b1;
    end
  endtask
  // Sends one nibble LSB first, each bit as inverse then true half.
  task send_nib(input [3:0] n);
    integer i;
    begin
      for (i = 0; i < 8; i = i + 1) begin
        @(posedge core_clk);
        line_rx_act <= 1'b1;
        line_rx_pos <= n[i/2] ^ !i[0];
        line_rx_neg <= !(n[i/2] ^ !i[0]);
      end
      @(posedge core_clk);
      line_rx_act <= 1'b0;
      line_rx_pos <= !line_rx_pos; // A released line must not keep its value.
      line_rx_neg <= !line_rx_neg;
    end
  endtask
endmodule

// File: dv/phy_mode_power_duplex_control_test.sv
// Self-checking bench of the mode-control block.
`timescale 1ns/100ps
`include "pmdc_defs.vh"
module phy_mode_power_duplex_control_test;
  reg         core_clk, nrst, psel, penable, pwrite, tx_valid, rerr;
  reg  [7:0]  paddr;
  reg  [31:0] pwdata, rdat;
  reg  [3:0]  txd, last_rx;
  reg  [15:0] line_bits;
  wire [31:0] prdata;
  wire [3:0]  rxd_r, lp_abil;
  wire        pready, pslverr, tx_ready, rx_dv_r, crs_r, col_r, tp_pos_r, tp_neg_r, tp_oe_r;
  wire        line_rx_pos, line_rx_neg, line_rx_act, lp_abil_valid, en_100_r, en_10_r;
  integer     bad_count, tests_run, cyc, crs_cnt, col_cnt, dv_cnt, oe_cnt;
  pmdc_top uut (.core_clk(core_clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .txd(txd), .rxd_r(rxd_r), .rx_dv_r(rx_dv_r),
    .crs_r(crs_r), .col_r(col_r), .tp_pos_r(tp_pos_r), .tp_neg_r(tp_neg_r), .tp_oe_r(tp_oe_r),
    .line_rx_pos(line_rx_pos), .line_rx_neg(line_rx_neg), .line_rx_act(line_rx_act),
    .lp_abil(lp_abil), .lp_abil_valid(lp_abil_valid), .en_100_r(en_100_r), .en_10_r(en_10_r));
  pmdc_lp_model u_lp (.core_clk(core_clk), .line_rx_pos(line_rx_pos), .line_rx_neg(line_rx_neg),
    .line_rx_act(line_rx_act), .lp_abil(lp_abil), .lp_abil_valid(lp_abil_valid));
  // Free-running clock.
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  // Counts activity cycles and cuts a hang short.
  always @(posedge core_clk) begin
    cyc = cyc + 1;
    if (crs_r === 1'b1) crs_cnt = crs_cnt + 1;
    if (col_r === 1'b1) col_cnt = col_cnt + 1;
    if (tp_oe_r === 1'b1) begin
      oe_cnt = oe_cnt + 1;
      line_bits = {line_bits[13:0], tp_pos_r, tp_neg_r};
    end
    if (rx_dv_r === 1'b1) begin
      dv_cnt = dv_cnt + 1;
      last_rx = rxd_r;
    end
    if (cyc > 20000) begin
      bad_count = bad_count + 1;
      wrap_up;
    end
  end
  task chk(input [95:0] got, input [95:0] exp);
    begin
      tests_run = tests_run + 1;
      if (got !== exp) begin
        bad_count = bad_count + 1;
        $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  // One APB transfer; waits for pready, then releases.
  task apb(input w, input [7:0] a, input [31:0] d);
    begin
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      @(posedge core_clk);
      while (pready !== 1'b1) @(posedge core_clk);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge core_clk);
    end
  endtask
  // Polls status until the masked bits read as expected, at most 20 more reads, then compares.
  task stat(input [3:0] m, input [3:0] e);
    integer n;
    begin
      apb(1'b0, `PMDC_ADDR_STAT, 32'h0000_0000);
      for (n = 0; n < 20 && (rdat[3:0] & m) !== e; n = n + 1) apb(1'b0, `PMDC_ADDR_STAT, 32'h0000_0000);
      chk(rdat[3:0] & m, e);
    end
  endtask
  function [31:0] ctl(input a, input s, input f);
    ctl = {18'h0_0000, s, a, 3'h0, f, 8'h00};
  endfunction
  task mode(input s, input f);
    apb(1'b1, `PMDC_ADDR_CTRL, ctl(1'b0, s, f));
  endtask
  task clr;
    begin
      crs_cnt = 0;
      col_cnt = 0;
      dv_cnt = 0;
      oe_cnt = 0;
      line_bits = 16'h0000;
    end
  endtask
  task tx_nib(input [3:0] n);
    begin
      tx_valid <= 1'b1;
      txd <= n;
      @(posedge core_clk);
      tx_valid <= 1'b0;
      repeat (20) @(posedge core_clk);
    end
  endtask
  task t_reset;
    begin
      chk(en_100_r, 1'b1);
      chk(en_10_r, 1'b1);
      chk(tx_ready, 1'b1);
      apb(1'b0, `PMDC_ADDR_CTRL, 32'h0000_0000);
      chk(rdat, ctl(1'b1, 1'b0, 1'b1));
      apb(1'b0, `PMDC_ADDR_ABIL, 32'h0000_0000);
      chk(rdat, 32'h0000_000F);
      apb(1'b0, 8'h10, 32'h0000_0000);
      chk({rerr, rdat}, 33'h1_0000_0000);
    end
  endtask
  task t_an;
    integer i;
    begin
      for (i = 0; i < 4; i = i + 1) begin
        u_lp.set_abil(4'h8 >> i);
        stat(4'h3, {2'h0, ~i[0], ~i[1]});
      end
      mode(1'b1, 1'b0);
      stat(4'h3, 4'h1);
      u_lp.set_abil(4'h8);
      stat(4'h3, 4'h1);
      apb(1'b1, `PMDC_ADDR_CTRL, ctl(1'b1, 1'b0, 1'b0));
      stat(4'h3, 4'h3);
    end
  endtask
  task t_gate;
    begin
      mode(1'b0, 1'b1);
      apb(1'b1, `PMDC_ADDR_CTRL2, 32'h0000_0001);
      stat(4'hC, 4'h8);
      apb(1'b1, `PMDC_ADDR_CTRL2, 32'h0000_0002);
      stat(4'hC, 4'hC);
      mode(1'b1, 1'b1);
      stat(4'hC, 4'h4);
      apb(1'b1, `PMDC_ADDR_CTRL2, 32'h0000_0000);
      stat(4'hC, 4'hC);
    end
  endtask
  task t_dup;
    begin
      mode(1'b0, 1'b1);
      clr;
      tx_nib(4'h6);
      repeat (130) @(posedge core_clk);
      chk(oe_cnt, 8);
      chk(line_bits, 16'h9669);
      chk({crs_cnt, col_cnt, dv_cnt}, 96'h0);
      mode(1'b0, 1'b0);
      clr;
      tx_nib(4'h9);
      repeat (130) @(posedge core_clk);
      chk({dv_cnt, last_rx}, {32'h1, 4'h9});
      chk({crs_cnt >= 8, col_cnt > 0}, 2'h3);
      mode(1'b1, 1'b0);
      clr;
      fork
        tx_nib(4'h3);
        u_lp.send_nib(4'hC);
      join
      chk({oe_cnt, col_cnt > 0}, {32'h5, 1'b1});
      chk(line_bits, 16'h0281);
      mode(1'b1, 1'b1);
      clr;
      fork
        tx_nib(4'h3);
        u_lp.send_nib(4'hC);
      join
      chk({col_cnt, crs_cnt > 0}, {32'h0, 1'b1});
    end
  endtask
  task t_rx;
    begin
      mode(1'b0, 1'b1);
      clr;
      u_lp.send_nib(4'hA);
      repeat (10) @(posedge core_clk);
      chk({dv_cnt, last_rx}, {32'h1, 4'hA});
    end
  endtask
  task t_fifo;
    integer acc;
    begin
      acc = 0;
      clr;
      tx_valid <= 1'b1;
      txd <= 4'h5;
      @(posedge core_clk);
      while (tx_ready === 1'b1 && acc < 20) begin
        acc = acc + 1;
        @(posedge core_clk);
      end
      tx_valid <= 1'b0;
      repeat (100) @(posedge core_clk);
      chk({acc >= 4, oe_cnt}, {1'b1, 32'h8 * acc});
    end
  endtask
  task wrap_up;
    begin
      $display("Mismatches %0d of %0d checks", bad_count, tests_run);
      if (bad_count == 0 && tests_run > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
    end
  endtask
  // Reset, then the scenarios in turn.
  initial begin
    nrst = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    tx_valid = 1'b0;
    txd = 4'h0;
    bad_count = 0;
    tests_run = 0;
    cyc = 0;
    clr;
    repeat (12) @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk);
    t_reset;
    t_an;
    t_gate;
    t_dup;
    t_rx;
    t_fifo;
    wrap_up;
  end
endmodule
bind pmdc_top pmdc_sva u_sva (.core_clk(core_clk), .nrst(nrst), .psel(psel), .penable(penable),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .tx_valid(tx_valid),
  .tx_ready(tx_ready), .rx_dv_r(rx_dv_r), .tp_pos_r(tp_pos_r), .tp_neg_r(tp_neg_r),
  .en_100_r(en_100_r), .en_10_r(en_10_r));
